// >>> hdl/eopc_top.sv
`include "eopc_regs.svh"

module eopc_top
    import eopc_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Wishbone classic slave
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [7:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_dat_wr,
    output logic [31:0] wb_dat_rd,
    output logic wb_ack,
    // Camera events from the same clock domain
    input wire logic exposure_req,
    input wire logic line_start,
    input wire logic trigger_event,
    input wire logic frame_busy,
    input wire logic readout_start,
    input wire logic readout_end,
    input wire logic acquisition_end,
    // General inputs from pins, already debounced
    input wire logic [1:0] general_in,
    // Opto outputs, high while current is drawn through the load
    output logic [1:0] out_closed,
    // Qualified camera events
    output logic exposure_start,
    output logic trigger_valid,
    output logic trigger_invalid
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    eopc_top_t s_r;
    eopc_top_t s_nxt;
    logic [1:0] ch_busy;
    logic [1:0] ch_ignored;
    logic [1:0] ch_event;
    logic [15:0] ev_vec;
    logic bus_req;
    logic bus_wr;
    logic [31:0] sel_mask;
    logic ch_hit;
    logic ch_idx;
    logic [3:0] ch_off;
    logic exp_now;
    logic cnt_valid_clr;
    logic cnt_invalid_clr;
    logic [1:0] miss_clr;

    function automatic eopc_top_t rst_value();
        eopc_top_t v;
        v = '0;
        for (int i = 0; i < 2; i++) begin
            v.mode[i] = `EOPC_MODE_OPEN;
            v.active_open[i] = `EOPC_POL_RESET;
            v.delay[i] = `EOPC_DELAY_RESET;
            v.length[i] = eopc_us_t'(`EOPC_LEN_MIN_US);
        end
        return v;
    endfunction

    // Byte enables merged into the old value of a word
    function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                          input logic [31:0] mask);
        return (old_v & ~mask) | (new_v & mask);
    endfunction

    // Out-of-range values saturate instead of wrapping the counters
    function automatic eopc_us_t clamp_delay(input logic [31:0] v);
        if (v > `EOPC_MAX_US) begin
            return eopc_us_t'(`EOPC_MAX_US);
        end
        return eopc_us_t'(v);
    endfunction

    function automatic eopc_us_t clamp_length(input logic [31:0] v);
        if (v < `EOPC_LEN_MIN_US) begin
            return eopc_us_t'(`EOPC_LEN_MIN_US);
        end else if (v > `EOPC_MAX_US) begin
            return eopc_us_t'(`EOPC_MAX_US);
        end
        return eopc_us_t'(v);
    endfunction

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    assign bus_req = wb_cyc && wb_stb && !s_r.ack;
    assign bus_wr = bus_req && wb_we;
    assign sel_mask = {{8{wb_sel[3]}}, {8{wb_sel[2]}}, {8{wb_sel[1]}}, {8{wb_sel[0]}}};
    assign ch_hit = (wb_adr[7:5] == 3'h0);
    assign ch_idx = wb_adr[4];
    assign ch_off = wb_adr[3:0];

    always_comb begin
        cnt_valid_clr = 1'b0;
        cnt_invalid_clr = 1'b0;
        miss_clr = 2'h0;
        if (bus_wr) begin
            if (wb_adr == `EOPC_OFF_CNT_VALID) begin
                cnt_valid_clr = 1'b1;
            end else if (wb_adr == `EOPC_OFF_CNT_INVALID) begin
                cnt_invalid_clr = 1'b1;
            end else if (wb_adr == `EOPC_OFF_STATUS && wb_sel[0]) begin
                miss_clr = wb_dat_wr[`EOPC_STAT_MISS_LSB +: 2];
            end
        end
    end

    // ------------------------------------------------------------
    // Event sources
    // ------------------------------------------------------------
    // Exposure starts at once, or at a line start when aligned
    assign exp_now = s_r.sync_exp ? ((s_r.exp_pend || exposure_req) && line_start)
                                  : exposure_req;

    // Indexed by mode code, so static and unused codes never fire
    always_comb begin
        ev_vec = 16'h0000;
        ev_vec[`EOPC_MODE_STROBE] = s_r.exp_start;
        ev_vec[`EOPC_MODE_VALID] = s_r.trig_valid;
        ev_vec[`EOPC_MODE_INVALID] = s_r.trig_invalid;
        ev_vec[`EOPC_MODE_RO_START] = readout_start;
        ev_vec[`EOPC_MODE_RO_END] = readout_end;
        ev_vec[`EOPC_MODE_ACQ_END] = acquisition_end;
        ev_vec[`EOPC_MODE_INPUT1] = s_r.gin_rise[0];
        ev_vec[`EOPC_MODE_INPUT2] = s_r.gin_rise[1];
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;

        // Microsecond time base
        if (s_r.tick_cnt == 6'(`EOPC_TICK_CYC - 1)) begin
            s_nxt.tick_cnt = 6'h00;
            s_nxt.tick = 1'b1;
        end else begin
            s_nxt.tick_cnt = s_r.tick_cnt + 6'h01;
            s_nxt.tick = 1'b0;
        end

        // Pin synchronisers and rising edges
        s_nxt.gin_s1 = general_in;
        s_nxt.gin_s2 = s_r.gin_s1;
        s_nxt.gin_prev = s_r.gin_s2;
        s_nxt.gin_rise = s_r.gin_s2 & ~s_r.gin_prev;

        // Trigger qualification against the frame in progress
        s_nxt.trig_valid = trigger_event && !frame_busy;
        s_nxt.trig_invalid = trigger_event && frame_busy;

        // Exposure alignment
        s_nxt.exp_start = exp_now;
        if (!s_r.sync_exp || exp_now) begin
            s_nxt.exp_pend = 1'b0;
        end else if (exposure_req) begin
            s_nxt.exp_pend = 1'b1;
        end

        // Statistics; a new event wins over a software clear
        if (cnt_valid_clr) begin
            s_nxt.cnt_valid = {15'h0000, s_r.trig_valid};
        end else begin
            s_nxt.cnt_valid = s_r.cnt_valid + {15'h0000, s_r.trig_valid};
        end
        if (cnt_invalid_clr) begin
            s_nxt.cnt_invalid = {15'h0000, s_r.trig_invalid};
        end else begin
            s_nxt.cnt_invalid = s_r.cnt_invalid + {15'h0000, s_r.trig_invalid};
        end
        s_nxt.miss = (s_r.miss & ~miss_clr) | ch_ignored;

        // Register writes
        s_nxt.ack = bus_req;
        if (bus_wr) begin
            if (ch_hit && ch_off == `EOPC_OFF_MODE) begin
                if (wb_sel[0]) begin
                    s_nxt.mode[ch_idx] = wb_dat_wr[`EOPC_MODE_LSB +: 4];
                    s_nxt.active_open[ch_idx] = wb_dat_wr[`EOPC_POL_BIT];
                end
            end else if (ch_hit && ch_off == `EOPC_OFF_DELAY) begin
                s_nxt.delay[ch_idx] = clamp_delay(merge({10'h000, s_r.delay[ch_idx]},
                                                        wb_dat_wr, sel_mask));
            end else if (ch_hit && ch_off == `EOPC_OFF_LENGTH) begin
                s_nxt.length[ch_idx] = clamp_length(merge({10'h000, s_r.length[ch_idx]},
                                                          wb_dat_wr, sel_mask));
            end else if (wb_adr == `EOPC_OFF_CTRL) begin
                if (wb_sel[0]) begin
                    s_nxt.sync_exp = wb_dat_wr[`EOPC_CTRL_SYNC_BIT];
                end
            end
        end

        // Register reads; unmapped words answer zero
        s_nxt.rdata = 32'h00000000;
        if (bus_req && !wb_we) begin
            if (ch_hit && ch_off == `EOPC_OFF_MODE) begin
                s_nxt.rdata[`EOPC_MODE_LSB +: 4] = s_r.mode[ch_idx];
                s_nxt.rdata[`EOPC_POL_BIT] = s_r.active_open[ch_idx];
            end else if (ch_hit && ch_off == `EOPC_OFF_DELAY) begin
                s_nxt.rdata = {10'h000, s_r.delay[ch_idx]};
            end else if (ch_hit && ch_off == `EOPC_OFF_LENGTH) begin
                s_nxt.rdata = {10'h000, s_r.length[ch_idx]};
            end else if (wb_adr == `EOPC_OFF_CTRL) begin
                s_nxt.rdata[`EOPC_CTRL_SYNC_BIT] = s_r.sync_exp;
            end else if (wb_adr == `EOPC_OFF_STATUS) begin
                s_nxt.rdata[`EOPC_STAT_OUT_LSB +: 2] = out_closed;
                s_nxt.rdata[`EOPC_STAT_BUSY_LSB +: 2] = ch_busy;
                s_nxt.rdata[`EOPC_STAT_MISS_LSB +: 2] = s_r.miss;
                s_nxt.rdata[`EOPC_STAT_FRAME_BIT] = frame_busy;
                s_nxt.rdata[`EOPC_STAT_PEND_BIT] = s_r.exp_pend;
            end else if (wb_adr == `EOPC_OFF_CNT_VALID) begin
                s_nxt.rdata = {16'h0000, s_r.cnt_valid};
            end else if (wb_adr == `EOPC_OFF_CNT_INVALID) begin
                s_nxt.rdata = {16'h0000, s_r.cnt_invalid};
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s_r <= rst_value();
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // Output channels
    // ------------------------------------------------------------
    for (genvar g = 0; g < 2; g++) begin : g_ch
        assign ch_event[g] = ev_vec[s_r.mode[g]];

        eopc_channel u_channel (
            .clk_sys(clk_sys),
            .rst_n(rst_n),
            .tick_us(s_r.tick),
            .event_pulse(ch_event[g]),
            .mode(s_r.mode[g]),
            .active_open(s_r.active_open[g]),
            .delay_us(s_r.delay[g]),
            .length_us(s_r.length[g]),
            .out_closed(out_closed[g]),
            .busy(ch_busy[g]),
            .event_ignored(ch_ignored[g])
        );
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign wb_ack = s_r.ack;
    assign wb_dat_rd = s_r.rdata;
    assign exposure_start = s_r.exp_start;
    assign trigger_valid = s_r.trig_valid;
    assign trigger_invalid = s_r.trig_invalid;

endmodule

// >>> hdl/eopc_regs.svh
`ifndef EOPC_REGS_SVH
`define EOPC_REGS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses, one aligned word each)
// ----------------------------------------------------------------
`define EOPC_CH_STRIDE 8'h10
`define EOPC_OFF_MODE 4'h0
`define EOPC_OFF_DELAY 4'h4
`define EOPC_OFF_LENGTH 4'h8
`define EOPC_OFF_CTRL 8'h20
`define EOPC_OFF_STATUS 8'h24
`define EOPC_OFF_CNT_VALID 8'h28
`define EOPC_OFF_CNT_INVALID 8'h2C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define EOPC_MODE_LSB 0
`define EOPC_POL_BIT 4
`define EOPC_CTRL_SYNC_BIT 0
`define EOPC_STAT_OUT_LSB 0
`define EOPC_STAT_BUSY_LSB 2
`define EOPC_STAT_MISS_LSB 4
`define EOPC_STAT_FRAME_BIT 6
`define EOPC_STAT_PEND_BIT 7

// ----------------------------------------------------------------
// Event mode codes
// ----------------------------------------------------------------
`define EOPC_MODE_OPEN 4'h0
`define EOPC_MODE_CLOSE 4'h1
`define EOPC_MODE_STROBE 4'h2
`define EOPC_MODE_VALID 4'h4
`define EOPC_MODE_INVALID 4'h5
`define EOPC_MODE_RO_START 4'h6
`define EOPC_MODE_RO_END 4'h7
`define EOPC_MODE_ACQ_END 4'h8
`define EOPC_MODE_INPUT1 4'h9
`define EOPC_MODE_INPUT2 4'hA

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define EOPC_US_W 22
`define EOPC_US_ONE 22'h000001
`define EOPC_POL_RESET 1'b1
`define EOPC_DELAY_RESET 22'h000000
`define EOPC_LEN_MIN_US 32'h00000064
`define EOPC_MAX_US 32'h003D0900
`define EOPC_CLK_MHZ 50
`define EOPC_TICK_US 1
`define EOPC_TICK_CYC (`EOPC_TICK_US * `EOPC_CLK_MHZ)

`endif

// >>> hdl/eopc_pkg.sv
`include "eopc_regs.svh"

package eopc_pkg;

    typedef logic [`EOPC_US_W-1:0] eopc_us_t;

    typedef enum logic [1:0] {
        EOPC_CH_IDLE,
        EOPC_CH_DELAY,
        EOPC_CH_PULSE
    } eopc_ch_state_t;

    typedef struct packed {
        eopc_ch_state_t state;
        eopc_us_t cnt;
        logic out_closed;
        logic ignored;
    } eopc_ch_t;

    typedef struct packed {
        logic [1:0][3:0] mode;
        logic [1:0] active_open;
        eopc_us_t [1:0] delay;
        eopc_us_t [1:0] length;
        logic sync_exp;
        logic ack;
        logic [31:0] rdata;
        logic [5:0] tick_cnt;
        logic tick;
        logic [1:0] gin_s1;
        logic [1:0] gin_s2;
        logic [1:0] gin_prev;
        logic [1:0] gin_rise;
        logic exp_pend;
        logic exp_start;
        logic trig_valid;
        logic trig_invalid;
        logic [1:0] miss;
        logic [15:0] cnt_valid;
        logic [15:0] cnt_invalid;
    } eopc_top_t;

endpackage

// >>> hdl/eopc_channel.sv
`include "eopc_regs.svh"

module eopc_channel
    import eopc_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Time base and event
    input wire logic tick_us,
    input wire logic event_pulse,
    // Configuration
    input wire logic [3:0] mode,
    input wire logic active_open,
    input wire eopc_us_t delay_us,
    input wire eopc_us_t length_us,
    // Status
    output logic out_closed,
    output logic busy,
    output logic event_ignored
);

    eopc_ch_t s_r;
    eopc_ch_t s_nxt;
    logic is_pulse;

    function automatic eopc_ch_t rst_value();
        eopc_ch_t v;
        v = '0;
        v.state = EOPC_CH_IDLE;
        return v;
    endfunction

    assign is_pulse = (mode == `EOPC_MODE_STROBE) ||
                      ((mode >= `EOPC_MODE_VALID) && (mode <= `EOPC_MODE_INPUT2));

    always_comb begin
        s_nxt = s_r;
        s_nxt.ignored = 1'b0;
        case (s_r.state)
            EOPC_CH_IDLE: begin
                s_nxt.cnt = '0;
                if (is_pulse && event_pulse) begin
                    // Zero delay skips straight to the pulse
                    s_nxt.state = (delay_us == '0) ? EOPC_CH_PULSE : EOPC_CH_DELAY;
                end
            end
            EOPC_CH_DELAY: begin
                s_nxt.ignored = event_pulse;
                if (tick_us) begin
                    if (s_r.cnt + `EOPC_US_ONE >= delay_us) begin
                        s_nxt.state = EOPC_CH_PULSE;
                        s_nxt.cnt = '0;
                    end else begin
                        s_nxt.cnt = s_r.cnt + `EOPC_US_ONE;
                    end
                end
            end
            EOPC_CH_PULSE: begin
                s_nxt.ignored = event_pulse;
                if (tick_us) begin
                    if (s_r.cnt + `EOPC_US_ONE >= length_us) begin
                        s_nxt.state = EOPC_CH_IDLE;
                        s_nxt.cnt = '0;
                    end else begin
                        s_nxt.cnt = s_r.cnt + `EOPC_US_ONE;
                    end
                end
            end
            default: begin
                s_nxt.state = EOPC_CH_IDLE;
            end
        endcase
        // Leaving a pulse mode aborts anything in flight
        if (!is_pulse) begin
            s_nxt.state = EOPC_CH_IDLE;
            s_nxt.cnt = '0;
            s_nxt.ignored = 1'b0;
        end
        if (mode == `EOPC_MODE_CLOSE) begin
            s_nxt.out_closed = 1'b1;
        end else if (is_pulse) begin
            // Active closed draws current; idle rests in the opposite state
            s_nxt.out_closed = (s_nxt.state == EOPC_CH_PULSE) ? !active_open : active_open;
        end else begin
            s_nxt.out_closed = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s_r <= rst_value();
        end else begin
            s_r <= s_nxt;
        end
    end

    assign out_closed = s_r.out_closed;
    assign busy = (s_r.state != EOPC_CH_IDLE);
    assign event_ignored = s_r.ignored;

endmodule

// >>> verification/eopc_top_checker.sv
module eopc_top_checker (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Register bus
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic [31:0] wb_dat_rd,
    input wire logic wb_ack,
    // Camera events
    input wire logic exposure_req,
    input wire logic line_start,
    input wire logic trigger_event,
    input wire logic frame_busy,
    // Outputs
    input wire logic [1:0] out_closed,
    input wire logic exposure_start,
    input wire logic trigger_valid,
    input wire logic trigger_invalid
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence s_req;
        wb_cyc && wb_stb && !wb_ack;
    endsequence
    sequence s_answer;
        wb_ack ##1 !wb_ack;
    endsequence

    chk_bus_answer: assert property (s_req |=> s_answer)
        else $error("bus request not answered by a single ack");
    chk_read_idle: assert property (!wb_ack |-> wb_dat_rd == 32'h0)
        else $error("read data not zero outside ack");
    chk_ack_cause: assert property ($rose(wb_ack) |-> $past(wb_cyc && wb_stb))
        else $error("ack without request");
    chk_valid_class: assert property (
        trigger_event && !frame_busy |=> trigger_valid && !trigger_invalid)
        else $error("idle trigger not classed valid");
    chk_invalid_class: assert property (
        trigger_event && frame_busy |=> trigger_invalid && !trigger_valid)
        else $error("busy trigger not classed invalid");
    chk_valid_cause: assert property (trigger_valid |-> $past(trigger_event && !frame_busy))
        else $error("valid trigger without cause");
    chk_invalid_cause: assert property (
        trigger_invalid |-> $past(trigger_event && frame_busy))
        else $error("invalid trigger without cause");
    chk_exposure_cause: assert property (
        exposure_start |-> $past(exposure_req || line_start))
        else $error("exposure start without request or line");
    chk_reset_quiet: assert property ($rose(rst_n) |-> out_closed == 2'b00 && !wb_ack)
        else $error("outputs not quiet after reset");
endmodule

bind eopc_top eopc_top_checker u_chk (
    .clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
    .wb_dat_rd(wb_dat_rd), .wb_ack(wb_ack), .exposure_req(exposure_req),
    .line_start(line_start), .trigger_event(trigger_event), .frame_busy(frame_busy),
    .out_closed(out_closed), .exposure_start(exposure_start),
    .trigger_valid(trigger_valid), .trigger_invalid(trigger_invalid)
);

// >>> verification/eopc_load_model.sv
module eopc_load_model (
    // Clock
    input wire logic clk_sys,
    // Opto outputs, high while current flows
    input wire logic [1:0] out_closed,
    // Observed load activity
    output logic [1:0][31:0] last_width,
    output logic [1:0][15:0] edge_cnt
);
    logic [1:0][31:0] run;
    logic [1:0] prev;

    // A lamp has no reset: it only sees the level it is given
    initial begin
        last_width = '0;
        edge_cnt = '0;
        run = '0;
        prev = 2'b00;
    end

    always @(posedge clk_sys) begin
        for (int c = 0; c < 2; c++) begin
            if (out_closed[c] !== prev[c]) begin
                last_width[c] <= run[c];
                run[c] <= 32'h1;
                edge_cnt[c] <= edge_cnt[c] + 16'h1;
            end else begin
                run[c] <= run[c] + 32'h1;
            end
        end
        prev <= out_closed;
    end
endmodule

// >>> verification/test_event_output_pulse_control.sv
`include "eopc_regs.svh"

module test_event_output_pulse_control;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int TICK = `EOPC_TICK_CYC;
    localparam int PULSE = TICK * `EOPC_LEN_MIN_US;

    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_dat_wr = 32'h0;
    logic [31:0] wb_dat_rd;
    logic wb_ack;
    logic [7:0] evt = 8'h00;
    logic frame_busy = 1'b0;
    logic [1:0] out_closed;
    logic [1:0][31:0] last_width;
    logic [1:0][15:0] edge_cnt;
    logic [15:0] e_other;
    int err_total = 0;
    int samples_checked = 0;

    always #10 clk_sys = ~clk_sys;

    eopc_top DUT (
        .clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
        .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_wr(wb_dat_wr),
        .wb_dat_rd(wb_dat_rd), .wb_ack(wb_ack), .exposure_req(evt[0]),
        .line_start(evt[1]), .trigger_event(evt[2]), .frame_busy(frame_busy),
        .readout_start(evt[3]), .readout_end(evt[4]), .acquisition_end(evt[5]),
        .general_in(evt[7:6]), .out_closed(out_closed), .exposure_start(),
        .trigger_valid(), .trigger_invalid()
    );

    eopc_load_model u_load (
        .clk_sys(clk_sys), .out_closed(out_closed),
        .last_width(last_width), .edge_cnt(edge_cnt)
    );

    // ----------------------------------------------------------------
    // Checking and bus tasks
    // ----------------------------------------------------------------
    task automatic check_word(input string what, input logic [31:0] exp,
                              input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_range(input string what, input int lo, input int hi, input int got);
        samples_checked++;
        if (got < lo || got > hi) begin
            err_total++;
            $display("Error %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask

    task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                       output logic [31:0] rd);
        int n;
        @(posedge clk_sys);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_sel <= 4'hF;
        wb_dat_wr <= wd;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (wb_ack !== 1'b1 && n < 50);
        rd = wb_dat_rd;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        if (wb_ack !== 1'b1) check_word("bus ack", 32'h1, 32'h0);
    endtask

    task automatic wr(input logic [7:0] adr, input logic [31:0] d);
        logic [31:0] v;
        bus(1'b1, adr, d, v);
    endtask

    task automatic rd_chk(input string what, input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] v;
        bus(1'b0, adr, 32'h0, v);
        check_word(what, exp, v);
    endtask

    // One-cycle event; a longer one would count as a second event
    task automatic fire(input int b);
        @(posedge clk_sys);
        evt[b] <= 1'b1;
        @(posedge clk_sys);
        evt[b] <= 1'b0;
    endtask

    task automatic set_ch(input int ch, input logic [3:0] mode, input logic pol, input int d);
        wr(8'(ch * 16) + `EOPC_OFF_DELAY, 32'(d));
        wr(8'(ch * 16) + `EOPC_OFF_MODE, {27'h0, pol, mode});
        repeat (3) @(posedge clk_sys);
    endtask

    // Fires event b and follows one pulse through the load model
    task automatic pulse(input int ch, input logic pol, input int d, input int b, input bit rt);
        logic [15:0] e0;
        int n;
        e0 = edge_cnt[ch];
        n = 0;
        check_word("rest level", 32'(pol), 32'(out_closed[ch]));
        fire(b);
        while (edge_cnt[ch] === e0 && n < 300000) begin
            @(posedge clk_sys);
            n++;
        end
        check_range("pulse delay", d > 0 ? (d - 1) * TICK : 1, d * TICK + 12, n);
        check_word("active level", 32'(!pol), 32'(out_closed[ch]));
        if (rt) fire(b);
        while (edge_cnt[ch] === e0 + 16'h1 && n < 600000) begin
            @(posedge clk_sys);
            n++;
        end
        if (d > 0) check_word("pulse width", 32'(PULSE), last_width[ch]);
        else check_range("pulse width", PULSE - TICK, PULSE + 2, int'(last_width[ch]));
    endtask

    task automatic end_of_test();
        $display("Checks %0d, errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Nine pulses of about 5000 cycles each; the limit leaves close to twice that
    initial begin
        #1800000;
        err_total++;
        end_of_test();
    end

    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd_chk("mode reset", `EOPC_OFF_MODE, 32'h10);
        rd_chk("delay reset", `EOPC_OFF_DELAY, 32'h0);
        rd_chk("length reset", `EOPC_OFF_LENGTH, `EOPC_LEN_MIN_US);
        check_word("outputs reset", 32'h0, 32'(out_closed));
        rd_chk("unmapped", 8'h30, 32'h0);
        wr(8'h10, 32'(`EOPC_MODE_CLOSE));
        repeat (2) @(posedge clk_sys);
        check_word("static closed", 32'h2, 32'(out_closed));
        fire(2);
        repeat (20) @(posedge clk_sys);
        check_word("static held", 32'h2, 32'(out_closed));
        rd_chk("no miss", `EOPC_OFF_STATUS, 32'h2);
        wr(8'h10, 32'(`EOPC_MODE_OPEN));
        repeat (2) @(posedge clk_sys);
        check_word("static open", 32'h0, 32'(out_closed));
        wr(`EOPC_OFF_DELAY, 32'hFFFFFFFF);
        rd_chk("delay clamp", `EOPC_OFF_DELAY, `EOPC_MAX_US);
        wr(`EOPC_OFF_LENGTH, 32'h5);
        rd_chk("length clamp", `EOPC_OFF_LENGTH, `EOPC_LEN_MIN_US);
        set_ch(0, `EOPC_MODE_VALID, 1'b0, 1);
        set_ch(1, `EOPC_MODE_INVALID, 1'b1, 3);
        e_other = edge_cnt[1];
        pulse(0, 1'b0, 1, 2, 1'b1);
        check_word("other idle", 32'(e_other), 32'(edge_cnt[1]));
        rd_chk("miss set", `EOPC_OFF_STATUS, 32'h12);
        wr(`EOPC_OFF_STATUS, 32'h30);
        rd_chk("miss clear", `EOPC_OFF_STATUS, 32'h2);
        rd_chk("valid count", `EOPC_OFF_CNT_VALID, 32'h3);
        @(posedge clk_sys);
        frame_busy <= 1'b1;
        e_other = edge_cnt[0];
        pulse(1, 1'b1, 3, 2, 1'b0);
        check_word("no valid pulse", 32'(e_other), 32'(edge_cnt[0]));
        frame_busy <= 1'b0;
        rd_chk("invalid count", `EOPC_OFF_CNT_INVALID, 32'h1);
        set_ch(0, `EOPC_MODE_STROBE, 1'b0, 0);
        pulse(0, 1'b0, 0, 0, 1'b0);
        wr(`EOPC_OFF_CTRL, 32'h1);
        e_other = edge_cnt[0];
        fire(0);
        repeat (10) @(posedge clk_sys);
        check_word("strobe held", 32'(e_other), 32'(edge_cnt[0]));
        rd_chk("exposure pending", `EOPC_OFF_STATUS, 32'h82);
        pulse(0, 1'b0, 0, 1, 1'b0);
        wr(`EOPC_OFF_CTRL, 32'h0);
        // Readout start, readout end, acquisition end, input one, input two
        for (int i = 0; i < 5; i++) begin
            set_ch(1, 4'(6 + i), i[0], 2);
            pulse(1, i[0], 2, 3 + i, 1'b0);
        end
        end_of_test();
    end
endmodule
